// File: hdl/irfmc_defines.vh
// Notes on behaviour
// (R01) Divider-select bit 7 clear feeds the input straight on; set routes it through the programmable pre-divider.
// (R02) Lock-at-8k bit 6 set passes the input through a preset divider so the DPLL sees 8 kHz; clear passes it direct.
// (R03) Each input has its own leaky-bucket activity monitor, and bits 5:4 pick one of four bucket profiles 00 to 11.
// (R04) Bits 3:0 give the nominal input frequency, and code 0000 means 8 kHz.
// (R05) Code 0001 means 1544 kHz or 2048 kHz, chosen by the line-standard select bit.
// (R06) Every reference input has the same layout at its own address, with reset defaults that differ per input.
// (R07) Input 3 resets to zero, takes host writes on all eight bits and reads back the last value written.
`ifndef IRFMC_DEFINES_VH
`define IRFMC_DEFINES_VH

// ----------------------------------------
// register map
// ----------------------------------------
`define IRFMC_NUM_INPUTS     14
`define IRFMC_ADDR_BASE      8'h20
`define IRFMC_ADDR_LAST      8'h2D
`define IRFMC_ADDR_INPUT3    8'h22
`define IRFMC_RST_INPUT3     8'h00
// per-input reset values, input 1 in the low byte
`define IRFMC_RST_ALL        112'h01_01_01_03_03_03_03_03_03_03_00_00_00_00
// writable bits per input; inputs 1 and 2 hold only the profile field
`define IRFMC_WMASK_ALL      112'hFF_FF_FF_FF_FF_FF_FF_FF_FF_FF_FF_FF_30_30
`define IRFMC_UNMAPPED_READ  8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define IRFMC_PREDIV_SEL_BIT 7
`define IRFMC_LOCK_8K_BIT    6
`define IRFMC_PROF_HI        5
`define IRFMC_PROF_LO        4
`define IRFMC_FREQ_HI        3
`define IRFMC_FREQ_LO        0

// ----------------------------------------
// frequency codes and nominal values in kHz
// ----------------------------------------
`define IRFMC_FC_8K          4'h0
`define IRFMC_FC_T1E1        4'h1
`define IRFMC_FC_6M48        4'h2
`define IRFMC_FC_19M44       4'h3
`define IRFMC_FC_25M92       4'h4
`define IRFMC_FC_38M88       4'h5
`define IRFMC_FC_51M84       4'h6
`define IRFMC_FC_77M76       4'h7
`define IRFMC_FC_155M52      4'h8
`define IRFMC_FC_2K          4'h9
`define IRFMC_FC_4K          4'hA
`define IRFMC_KHZ_8K         18'h00008
`define IRFMC_KHZ_1544       18'h00608
`define IRFMC_KHZ_2048       18'h00800
`define IRFMC_KHZ_6480       18'h01950
`define IRFMC_KHZ_19440      18'h04BF0
`define IRFMC_KHZ_25920      18'h06540
`define IRFMC_KHZ_38880      18'h097E0
`define IRFMC_KHZ_51840      18'h0CA80
`define IRFMC_KHZ_77760      18'h12FC0
`define IRFMC_KHZ_155520     18'h25F80
`define IRFMC_KHZ_2K         18'h00002
`define IRFMC_KHZ_4K         18'h00004
`define IRFMC_KHZ_NONE       18'h00000

// ----------------------------------------
// timing
// ----------------------------------------
`define IRFMC_CLK_NS         40
`define IRFMC_WINDOW_NS      160000
`define IRFMC_WINDOW_CYC     (`IRFMC_WINDOW_NS / `IRFMC_CLK_NS)
`define IRFMC_BUCKET_MAX     8'hFF

`endif

// File: hdl/irfmc_div.v
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// edge-counting divider, ratio 0 or 1 passes through
// ----------------------------------------
module irfmc_div (
	input  wire        i_clk,   // system clock
	input  wire        i_rst,   // async reset, high
	input  wire        i_in,    // sampled clock level
	input  wire [15:0] i_ratio, // divide ratio
	output wire        o_out    // divided level
);

	reg        prev_r;
	reg [15:0] cnt_r;
	reg [15:0] cnt_nxt;
	reg        out_r;
	wire       rise;
	wire       bypass;

	assign rise   = i_in & ~prev_r;
	assign bypass = (i_ratio < 16'h0002);
	assign o_out  = out_r;

	// wrap the counter one short of the ratio
	always @* begin
		if (cnt_r >= i_ratio - 16'h0001)
			cnt_nxt = 16'h0000;
		else
			cnt_nxt = cnt_r + 16'h0001;
	end

	// high for the first half of each divided period
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			prev_r <= 1'b0;
			cnt_r  <= 16'h0000;
			out_r  <= 1'b0;
		end else begin
			prev_r <= i_in;
			if (bypass) begin
				cnt_r <= 16'h0000;
				out_r <= i_in;
			end else if (rise) begin
				cnt_r <= cnt_nxt;
				out_r <= (cnt_nxt < (i_ratio >> 1));
			end
		end
	end

endmodule

`default_nettype wire

// File: hdl/irfmc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "irfmc_defines.vh"

// ----------------------------------------
// reference input frequency / monitor configuration bank
// ----------------------------------------
module irfmc_top (
	input  wire         i_clk,                  // system clock, 25 MHz
	input  wire         i_rst,                  // async reset, high
	input  wire         i_cs,                   // register port select
	input  wire         i_we,                   // write strobe
	input  wire         i_re,                   // read strobe
	input  wire [7:0]   i_addr,                 // register address
	input  wire [7:0]   i_wdata,                // write data
	output wire [7:0]   o_rdata,                // read data, registered
	output wire         o_rvalid,               // read data valid pulse
	input  wire         i_line_standard_select, // 0: 2048 kHz, 1: 1544 kHz
	input  wire [13:0]  i_ref,                  // reference clock levels
	input  wire [223:0] i_prediv_ratio,         // programmable ratio per input
	input  wire [31:0]  i_bucket_threshold,     // alarm level per profile
	output wire [13:0]  o_dpll_ref,             // clocks toward the DPLL
	output wire [13:0]  o_mon_ref,              // clocks toward the monitor
	output wire [13:0]  o_activity_alarm        // bucket at or over threshold
);

	// window count arrives as a plain integer; keep only the bits that fit
	localparam [31:0]  WINDOW_CYC = `IRFMC_WINDOW_CYC;
	localparam [12:0]  WINDOW_END = WINDOW_CYC[12:0] - 13'h0001;

	// per-input reset values and write masks, input 1 in the low byte
	localparam [111:0] RST_ALL    = `IRFMC_RST_ALL;
	localparam [111:0] WMASK_ALL  = `IRFMC_WMASK_ALL;

	// ----------------------------------------
	// nominal frequency from the code
	// ----------------------------------------
	function [17:0] irfmc_nominal_khz;
		input [3:0] code;
		input       line_std;
		begin
			case (code)
				`IRFMC_FC_8K:     irfmc_nominal_khz = `IRFMC_KHZ_8K;
				`IRFMC_FC_T1E1:   irfmc_nominal_khz = line_std ? `IRFMC_KHZ_1544 : `IRFMC_KHZ_2048;
				`IRFMC_FC_6M48:   irfmc_nominal_khz = `IRFMC_KHZ_6480;
				`IRFMC_FC_19M44:  irfmc_nominal_khz = `IRFMC_KHZ_19440;
				`IRFMC_FC_25M92:  irfmc_nominal_khz = `IRFMC_KHZ_25920;
				`IRFMC_FC_38M88:  irfmc_nominal_khz = `IRFMC_KHZ_38880;
				`IRFMC_FC_51M84:  irfmc_nominal_khz = `IRFMC_KHZ_51840;
				`IRFMC_FC_77M76:  irfmc_nominal_khz = `IRFMC_KHZ_77760;
				`IRFMC_FC_155M52: irfmc_nominal_khz = `IRFMC_KHZ_155520;
				`IRFMC_FC_2K:     irfmc_nominal_khz = `IRFMC_KHZ_2K;
				`IRFMC_FC_4K:     irfmc_nominal_khz = `IRFMC_KHZ_4K;
				default:          irfmc_nominal_khz = `IRFMC_KHZ_NONE;
			endcase
		end
	endfunction

	// ----------------------------------------
	// address decode and read port
	// ----------------------------------------
	wire [111:0] cfg_flat;
	wire         in_range;
	wire [7:0]   idx_full;
	wire [3:0]   idx;
	wire         rd_req;
	wire         wr_req;
	reg  [7:0]   rdata_r;
	reg          rvalid_r;

	// requests qualified by select; one access per edge
	assign rd_req   = i_cs & i_re;
	assign wr_req   = i_cs & i_we;
	assign in_range = (i_addr >= `IRFMC_ADDR_BASE) && (i_addr <= `IRFMC_ADDR_LAST);
	assign idx_full = i_addr - `IRFMC_ADDR_BASE;
	assign idx      = idx_full[3:0];
	assign o_rdata  = rdata_r;
	assign o_rvalid = rvalid_r;

	// reads return stored value; unmapped addresses read zero
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_r  <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= rd_req;
			if (rd_req) begin
				if (in_range)
					rdata_r <= cfg_flat[idx*8 +: 8]; // R07
				else
					rdata_r <= `IRFMC_UNMAPPED_READ;
			end
		end
	end

	// ----------------------------------------
	// monitor window timer, shared by all inputs
	// ----------------------------------------
	reg [12:0] win_cnt_r;
	reg        win_tick_r;

	// one counter for all buckets keeps area low; windows align across inputs
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			win_cnt_r  <= 13'h0000;
			win_tick_r <= 1'b0;
		end else begin
			win_tick_r <= (win_cnt_r == WINDOW_END);
			if (win_cnt_r == WINDOW_END)
				win_cnt_r <= 13'h0000;
			else
				win_cnt_r <= win_cnt_r + 13'h0001;
		end
	end

	// ----------------------------------------
	// per-input register, dividers and monitor
	// ----------------------------------------
	// one copy per input; only reset value, mask and address differ
	genvar g;
	generate
		for (g = 0; g < `IRFMC_NUM_INPUTS; g = g + 1) begin : in_g
			localparam [7:0]  RST_VAL = RST_ALL[g*8 +: 8];
			localparam [7:0]  WMASK   = WMASK_ALL[g*8 +: 8];
			localparam [31:0] ADDR_W  = `IRFMC_ADDR_BASE + g;
			localparam [7:0]  MY_ADDR = ADDR_W[7:0];

			reg  [7:0]  cfg_r;
			wire        wr_hit;
			wire [17:0] nominal_khz;
			wire [15:0] preset_ratio;
			wire [15:0] prog_ratio;
			wire [15:0] pre_ratio_sel;
			wire [15:0] lock_ratio_sel;
			wire        stage1;
			wire        stage2;
			wire [1:0]  profile;
			wire [7:0]  thr;
			reg         mon_prev_r;
			reg         seen_r;
			reg  [7:0]  bucket_r;
			reg         alarm_r;
			wire        mon_rise;
			wire        bucket_full;
			wire        bucket_empty;
			wire        alarm_nxt;

			// same layout at each address, own reset default
			assign wr_hit = wr_req & (i_addr == MY_ADDR); // R06

			// reserved bits stay zero on inputs that lack the fields
			always @(posedge i_clk or posedge i_rst) begin
				if (i_rst)
					cfg_r <= RST_VAL; // R07
				else if (wr_hit)
					cfg_r <= i_wdata & WMASK; // R07
			end

			assign cfg_flat[g*8 +: 8] = cfg_r;

			// nominal rate, then ratio down to 8 kHz
			assign nominal_khz  = irfmc_nominal_khz(cfg_r[`IRFMC_FREQ_HI:`IRFMC_FREQ_LO],
			                                        i_line_standard_select); // R04 R05
			assign preset_ratio = {1'b0, nominal_khz[17:3]};
			assign prog_ratio   = i_prediv_ratio[g*16 +: 16];

			// ratio 0 makes a divider transparent
			assign pre_ratio_sel  = cfg_r[`IRFMC_PREDIV_SEL_BIT] ? prog_ratio : 16'h0000; // R01
			assign lock_ratio_sel = cfg_r[`IRFMC_LOCK_8K_BIT] ? preset_ratio : 16'h0000; // R02

			irfmc_div u_prediv (
				.i_clk   (i_clk),
				.i_rst   (i_rst),
				.i_in    (i_ref[g]),
				.i_ratio (pre_ratio_sel),
				.o_out   (stage1)
			);

			// preset stage sits behind the programmable one
			irfmc_div u_lockdiv (
				.i_clk   (i_clk),
				.i_rst   (i_rst),
				.i_in    (stage1),
				.i_ratio (lock_ratio_sel),
				.o_out   (stage2)
			);

			assign o_mon_ref[g]  = stage1; // R01
			assign o_dpll_ref[g] = stage2; // R02

			// leaky bucket: fill on a silent window, leak on an active one
			assign profile = cfg_r[`IRFMC_PROF_HI:`IRFMC_PROF_LO];
			assign thr     = i_bucket_threshold[profile*8 +: 8]; // R03

			// bucket limits; a zero threshold parks the alarm low
			assign mon_rise     = stage1 & ~mon_prev_r;
			assign bucket_full  = (bucket_r == `IRFMC_BUCKET_MAX);
			assign bucket_empty = (bucket_r == 8'h00);
			assign alarm_nxt    = (thr != 8'h00) && (bucket_r >= thr); // R03

			// bucket steps once per window tick, alarm one edge later
			always @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					mon_prev_r <= 1'b0;
					seen_r     <= 1'b0;
					bucket_r   <= 8'h00;
					alarm_r    <= 1'b0;
				end else begin
					mon_prev_r <= stage1;
					// an edge in the closing cycle counts toward the next window
					seen_r <= mon_rise | (seen_r & ~win_tick_r);
					if (win_tick_r) begin
						if (seen_r) begin
							if (!bucket_empty)
								bucket_r <= bucket_r - 8'h01;
						end else if (!bucket_full) begin
							bucket_r <= bucket_r + 8'h01;
						end
					end
					alarm_r <= alarm_nxt; // R03
				end
			end

			assign o_activity_alarm[g] = alarm_r;
		end
	endgenerate

endmodule

`default_nettype wire

// File: sim/input_ref_freq_monitor_cfg_bench.sv
`timescale 1ns/1ps
`default_nettype none
module input_ref_freq_monitor_cfg_bench;
	logic clk, rst, cs, we, re, lss;
	logic [7:0] addr, wdata, d;
	logic [13:0] run;
	wire logic [13:0] refs, dpll, mon, alarm;
	wire logic [7:0] rdata;
	wire logic rvalid;
	integer failures = 0, n_tests = 0, seed = 32'hE384, i;
	logic [15:0] per;
	irfmc_ref_src irfmc_ref_src_i (.i_clk(clk), .i_run(run), .o_ref(refs));
	irfmc_top irfmc_top_i (.i_clk(clk), .i_rst(rst), .i_cs(cs), .i_we(we), .i_re(re), .i_addr(addr),
		.i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid), .i_line_standard_select(lss), .i_ref(refs),
		.i_prediv_ratio({176'h0, 16'h0004, 32'h0}), .i_bucket_threshold(32'h02020200),
		.o_dpll_ref(dpll), .o_mon_ref(mon), .o_activity_alarm(alarm));
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	// ----
	// checks and bus cycles
	// ----
	task chk(input string nm, input [15:0] seen, input [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task report_and_stop;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task wr(input [7:0] a, input [7:0] v, input logic rb);
		@(posedge clk);
		#1 {cs, we, addr, wdata} = {2'b11, a, v};
		@(posedge clk);
		#1 {we, re} = {1'b0, rb};
		if (rb) begin
			@(posedge clk);
			#1 re = 0;
			chk("readback", rdata, v);
		end
		cs = 0;
	endtask
	task rd(input [7:0] a, input [7:0] exp);
		@(posedge clk);
		#1 {cs, re, addr} = {2'b11, a};
		@(posedge clk);
		#1 {cs, re} = 2'b00;
		chk("rvalid", rvalid, 1);
		chk("rdata", rdata, exp);
	endtask
	// cycles between the 2nd and 3rd rise of input 3 output
	task measure(input logic s, input [15:0] exp);
		integer k, n;
		logic p, c;
		n = 0;
		p = 1;
		per = 0;
		for (k = 0; k < 4000 && n < 3; k++) begin
			@(posedge clk);
			#2 c = s ? mon[2] : dpll[2];
			if (n == 2)
				per++;
			if (c && !p)
				n++;
			p = c;
		end
		if (n < 3) begin
			failures++;
			report_and_stop;
		end
		chk("period", per, exp);
	endtask
	// ----
	// main sequence
	// ----
	initial begin
		{rst, cs, we, re, lss, addr, wdata} = {5'b10000, 16'h0};
		run = 14'h3FFF;
		repeat (4) @(posedge clk);
		#1 rst = 0;
		for (i = 0; i < 14; i++)
			rd(8'h20 + i, i < 4 ? 8'h00 : i < 11 ? 8'h03 : 8'h01);
		for (i = 0; i < 14; i++)
			wr(8'h20 + i, 8'hFF, 0);
		for (i = 0; i < 14; i++)
			rd(8'h20 + i, i < 2 ? 8'h30 : 8'hFF);
		rd(8'h1F, 8'h00);
		rd(8'h2E, 8'h00);
		$display("register map done");
		repeat (20) begin
			d = $random(seed);
			@(posedge clk) #1 run = $random(seed);
			wr(8'h22, d, 1);
			d = $random(seed);
			rd((d < 8'h20 || d > 8'h2D) ? d : 8'hF0, 8'h00);
		end
		$display("random access done");
		@(posedge clk) #1 run = 14'h3FFF;
		wr(8'h22, 8'h80, 0);
		measure(1, 16'd8);
		wr(8'h22, 8'h00, 0);
		measure(1, 16'd2);
		wr(8'h22, 8'h41, 0);
		@(posedge clk) #1 lss = 1;
		measure(0, 16'd386);
		@(posedge clk) #1 lss = 0;
		measure(0, 16'd512);
		wr(8'h22, 8'h40, 0);
		measure(0, 16'd2);
		$display("clock paths done");
		@(posedge clk) #1 run = 14'h3FFB;
		wr(8'h22, 8'h10, 0);
		repeat (12100) @(posedge clk);
		#1 chk("alarm", alarm[2], 1);
		wr(8'h22, 8'h00, 0);
		repeat (4100) @(posedge clk);
		#1 chk("alarm", alarm[2], 0);
		wr(8'h22, 8'h20, 0);
		repeat (4) @(posedge clk);
		#1 chk("alarm", alarm[2], 1);
		@(posedge clk) #1 run = 14'h3FFF;
		repeat (16100) @(posedge clk);
		#1 chk("alarm", alarm[2], 0);
		$display("activity monitor done");
		report_and_stop;
	end
endmodule
`default_nettype wire

// File: sim/irfmc_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// register port, clock path and alarm checks
// ----
module irfmc_props (
	input wire logic        i_clk,              // clock
	input wire logic        i_rst,              // reset
	input wire logic        i_cs,               // select
	input wire logic        i_we,               // write
	input wire logic        i_re,               // read
	input wire logic [7:0]  i_addr,             // address
	input wire logic [7:0]  i_wdata,            // write data
	input wire logic [7:0]  o_rdata,            // read data
	input wire logic        o_rvalid,           // read valid
	input wire logic [13:0] i_ref,              // ref levels
	input wire logic [31:0] i_bucket_threshold, // thresholds
	input wire logic [13:0] o_dpll_ref,         // dpll side
	input wire logic [13:0] o_mon_ref,          // monitor side
	input wire logic [13:0] o_activity_alarm    // alarms
);
	logic [7:0] cfg_r; // shadow of input 3
	logic [1:0] up_r;  // edges since reset
	logic [7:0] thr;   // threshold of chosen profile
	assign thr = i_bucket_threshold[{cfg_r[5:4], 3'b000} +: 8];
	// shadow tracks writes; up_r masks the pipeline flush
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cfg_r <= 8'h00;
			up_r <= 2'h0;
		end else begin
			if (i_cs && i_we && i_addr == 8'h22)
				cfg_r <= i_wdata;
			if (up_r != 2'h3)
				up_r <= up_r + 2'h1;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_wr3; i_cs && i_we && i_addr == 8'h22; endsequence
	sequence s_rd3; i_cs && i_re && i_addr == 8'h22; endsequence
	a_rvalid_pulse: assert property (i_cs && i_re |=> o_rvalid)
		else $error("read not answered");
	a_rvalid_idle: assert property (!(i_cs && i_re) |=> !o_rvalid)
		else $error("stray read valid");
	a_write_readback: assert property (s_wr3 ##1 s_rd3 |=> o_rdata == $past(i_wdata, 2))
		else $error("readback differs");
	a_rdata_hold: assert property (!o_rvalid |-> $stable(o_rdata))
		else $error("read data moved");
	a_unmapped_zero: assert property (i_cs && i_re && (i_addr < 8'h20 || i_addr > 8'h2D) |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_mon_direct: assert property (up_r == 2'h3 && !cfg_r[7] && !$past(cfg_r[7]) |-> o_mon_ref[2] == $past(i_ref[2]))
		else $error("monitor path not direct");
	a_dpll_direct: assert property (up_r == 2'h3 && cfg_r[7:6] == 2'h0 && $past(cfg_r[7:6]) == 2'h0
		&& $past(cfg_r[7:6], 2) == 2'h0 |-> o_dpll_ref[2] == $past(i_ref[2], 2))
		else $error("dpll path not direct");
	a_alarm_thr: assert property ($rose(o_activity_alarm[2]) |-> $past(thr) != 8'h00)
		else $error("alarm with disabled profile");
endmodule
bind irfmc_top irfmc_props irfmc_props_i (.i_clk(i_clk), .i_rst(i_rst), .i_cs(i_cs), .i_we(i_we), .i_re(i_re),
	.i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_ref(i_ref),
	.i_bucket_threshold(i_bucket_threshold), .o_dpll_ref(o_dpll_ref), .o_mon_ref(o_mon_ref),
	.o_activity_alarm(o_activity_alarm));
`default_nettype wire

// File: sim/irfmc_ref_src.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// reference clock sources
// ----
module irfmc_ref_src (
	input wire logic        i_clk, // system clock
	input wire logic [13:0] i_run, // sources that toggle
	output logic     [13:0] o_ref  // reference levels
);
	initial o_ref = 14'h0000;
	// a stopped source parks low, as a dead line would
	always @(posedge i_clk)
		o_ref <= #1 ~o_ref & i_run;
endmodule
`default_nettype wire
